// >>> core/tcp_params.svh
// register offsets, field positions and reset values of the pwm block
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
`define TCP_OFF_CORE_CTRL 8'h00
`define TCP_OFF_PRESCALE 8'h04
`define TCP_OFF_PENDING 8'h08
`define TCP_OFF_CAP_ONE 8'h0C
`define TCP_OFF_CAP_TWO 8'h10
`define TCP_CH_BASE_NIB 4'h2
`define TCP_CH_PERIOD 2'h0
`define TCP_CH_COMPARE 2'h1
`define TCP_CH_DEADBAND_COMPARE_VALUE 2'h2
`define TCP_CH_CONTROL 2'h3
`define TCP_CORE_EN_BIT 0
`define TCP_CORE_SEL_LSB 8
`define TCP_CORE_NOUP_LSB 12
`define TCP_CC_EN_BIT 0
`define TCP_CC_POL_BIT 1
`define TCP_CC_PAIR_BIT 2
`define TCP_CC_SEL_LSB 10
`define TCP_CC_INTERRUPT_ENABLE_BIT 13
`define TCP_CC_INTERRUPT_TYPE_SELECT_BIT 14
`define TCP_CC_ISC_LSB 15
`define TCP_CC_DEADBAND_ENABLE_BIT 21
`define TCP_CC_DBPRE_LSB 22
`define TCP_CC_MASK 32'h03FFFC07
`define TCP_CORE_MASK 32'h00007701
`define TCP_PRESCALE_RESET 8'hFF
`define TCP_CAP_ONE_VALUE 32'h00400000
`endif

// >>> core/tcp_pkg.sv
// shared types of the pwm block
package tcp_pkg;
    typedef logic [15:0] tcp_count_type;
    typedef logic [2:0] tcp_sel_type;
endpackage

// >>> core/tcp_pwm.sv
// three channel pwm generator with dead band, apb register file
`timescale 1ns/1ps
`include "tcp_params.svh"
module tcp_pwm #(
    parameter int NUM_SCALERS = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] pwm_main,
    output logic [2:0] pwm_comp,
    output logic [2:0] pwm_tick,
    output logic pwm_irq
);
    localparam int NCH = 3;

    if (NUM_SCALERS < 1 || NUM_SCALERS > 8) begin : g_check
        $error("NUM_SCALERS must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // core registers and bus
    logic [31:0] core_q, core_d;
    logic [2:0] pend_q, pend_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic [7:0] reload_q [NUM_SCALERS];
    logic [NUM_SCALERS-1:0] pre_tick;
    logic [NCH-1:0] irq_raise;
    logic [15:0] rd_per [NCH];
    logic [15:0] rd_cmp [NCH];
    logic [7:0] rd_db [NCH];
    logic [31:0] rd_ctl [NCH];
    logic wr_en, core_en;
    logic [3:0] ch_nib;
    logic [1:0] ch_idx;

    assign core_en = core_q[`TCP_CORE_EN_BIT];
    assign wr_en = psel && penable && pwrite && pready_q;
    assign ch_nib = paddr[7:4] - `TCP_CH_BASE_NIB;
    assign ch_idx = ch_nib[1:0];

    // read data and ready are set up in the setup phase so they leave flops
    always_comb begin
        prdata_d = 32'h00000000;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            pready_d = 1'b1;
            if (paddr == `TCP_OFF_CORE_CTRL) begin
                prdata_d = core_q;
            end else if (paddr == `TCP_OFF_PRESCALE) begin
                if (32'(core_q[10:8]) < NUM_SCALERS) begin
                    prdata_d = {24'h000000, reload_q[core_q[10:8]]};
                end
            end else if (paddr == `TCP_OFF_PENDING) begin
                prdata_d = {29'h00000000, pend_q};
            end else if (paddr == `TCP_OFF_CAP_ONE) begin
                prdata_d = `TCP_CAP_ONE_VALUE;
            end else if (paddr == `TCP_OFF_CAP_TWO) begin
                prdata_d = 32'h00000000;
            end else if (paddr[7:4] >= 4'h2 && paddr[7:4] <= 4'h4 && paddr[1:0] == 2'h0) begin
                case (paddr[3:2])
                    `TCP_CH_PERIOD: prdata_d = {16'h0000, rd_per[ch_idx]};
                    `TCP_CH_COMPARE: prdata_d = {16'h0000, rd_cmp[ch_idx]};
                    `TCP_CH_DEADBAND_COMPARE_VALUE: prdata_d = {24'h000000, rd_db[ch_idx]};
                    default: prdata_d = rd_ctl[ch_idx];
                endcase
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // core control, pending bits and the merged interrupt
    always_comb begin
        core_d = core_q;
        pend_d = pend_q;
        if (wr_en && paddr == `TCP_OFF_CORE_CTRL) begin
            core_d = pwdata & `TCP_CORE_MASK;
        end
        if (wr_en && paddr == `TCP_OFF_PENDING) begin
            pend_d = pend_q & ~pwdata[2:0];
        end
        pend_d = pend_d | irq_raise; // set wins over a same-cycle clear
        irq_d = |pend_d;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_q <= 32'h00000000;
            pend_q <= 3'h0;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            core_q <= core_d;
            pend_q <= pend_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pwm_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // prescalers: tick once every reload+1 clocks
    for (genvar s = 0; s < NUM_SCALERS; s++) begin : g_pre
        logic [7:0] rl_d, cnt_q, cnt_d;
        always_comb begin
            rl_d = reload_q[s];
            if (wr_en && paddr == `TCP_OFF_PRESCALE && core_q[10:8] == 3'(s)) begin
                rl_d = pwdata[7:0];
            end
            cnt_d = cnt_q;
            pre_tick[s] = 1'b0;
            if (!core_en) begin
                cnt_d = reload_q[s];
            end else if (cnt_q == 8'h00) begin
                cnt_d = reload_q[s];
                pre_tick[s] = 1'b1;
            end else begin
                cnt_d = cnt_q - 8'h01;
            end
        end
        always_ff @(posedge core_clk) begin
            if (reset) begin
                reload_q[s] <= `TCP_PRESCALE_RESET;
                cnt_q <= `TCP_PRESCALE_RESET;
            end else begin
                reload_q[s] <= rl_d;
                cnt_q <= cnt_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channels
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        tcp_pkg::tcp_count_type per_sh_q, per_sh_d, cmp_sh_q, cmp_sh_d;
        tcp_pkg::tcp_count_type per_q, per_d, cmp_q, cmp_d, cnt_q, cnt_d;
        logic [7:0] db_sh_q, db_sh_d, dbc_q, dbc_d, dbn_q, dbn_d;
        logic [31:0] ctl_q, ctl_d;
        logic [3:0] dbp_q, dbp_d;
        logic [5:0] isc_q, isc_d;
        logic run_q, run_d, raw_q, raw_d, busy_q, busy_d;
        logic main_d, comp_d, main_q, comp_q, tick_d, tick_q, raise;
        logic step, wrap, hit, ch_wr, enabled, output_polarity, event_hit;
        tcp_pkg::tcp_sel_type sel;

        assign ch_wr = wr_en && paddr[7:4] == 4'(c + 2) && paddr[1:0] == 2'h0;
        assign sel = ctl_q[12:10];
        assign enabled = core_en && ctl_q[`TCP_CC_EN_BIT];
        assign output_polarity = ctl_q[`TCP_CC_POL_BIT];
        assign step = enabled && 32'(sel) < NUM_SCALERS && pre_tick[sel];
        assign wrap = step && run_q && cnt_q >= per_q;
        assign hit = step && run_q && cnt_q == cmp_q;
        assign event_hit = ctl_q[`TCP_CC_INTERRUPT_TYPE_SELECT_BIT] ? hit : wrap;

        always_comb begin
            per_sh_d = per_sh_q;
            cmp_sh_d = cmp_sh_q;
            db_sh_d = db_sh_q;
            ctl_d = ctl_q;
            if (ch_wr && paddr[3:2] == `TCP_CH_PERIOD) per_sh_d = pwdata[15:0];
            if (ch_wr && paddr[3:2] == `TCP_CH_COMPARE) cmp_sh_d = pwdata[15:0];
            if (ch_wr && paddr[3:2] == `TCP_CH_DEADBAND_COMPARE_VALUE) db_sh_d = pwdata[7:0];
            if (ch_wr && paddr[3:2] == `TCP_CH_CONTROL) ctl_d = pwdata & `TCP_CC_MASK;
            per_d = per_q;
            cmp_d = cmp_q;
            dbc_d = dbc_q;
            cnt_d = cnt_q;
            run_d = run_q;
            // active copies move only at a start or a wrap, and not under no-update
            if ((wrap || (step && !run_q)) && !core_q[`TCP_CORE_NOUP_LSB + c]) begin
                per_d = per_sh_q;
                cmp_d = cmp_sh_q;
                dbc_d = db_sh_q;
            end
            if (!enabled) begin
                run_d = 1'b0;
                cnt_d = 16'h0000;
            end else if (step && !run_q) begin
                run_d = 1'b1;
                cnt_d = 16'h0000;
            end else if (wrap) begin
                cnt_d = 16'h0000;
            end else if (step) begin
                cnt_d = cnt_q + 16'h0001;
            end
            raw_d = run_d && cnt_d > cmp_d && !wrap;
            // dead band: restart the delay on every switch of the pair
            busy_d = busy_q;
            dbn_d = dbn_q;
            dbp_d = dbp_q;
            if (!ctl_q[`TCP_CC_DEADBAND_ENABLE_BIT] || !ctl_q[`TCP_CC_PAIR_BIT] || !enabled) begin
                busy_d = 1'b0;
            end else if (raw_d != raw_q) begin
                busy_d = 1'b1;
                dbn_d = 8'h00;
                dbp_d = 4'h0;
            end else if (busy_q) begin
                if (dbp_q == ctl_q[25:22]) begin
                    dbp_d = 4'h0;
                    if (dbn_q == dbc_q) busy_d = 1'b0;
                    else dbn_d = dbn_q + 8'h01;
                end else begin
                    dbp_d = dbp_q + 4'h1;
                end
            end
            // deactivating side drops now; activating side waits out the delay
            main_d = output_polarity ? (raw_d && !busy_d) : !(raw_d && !busy_d);
            comp_d = ctl_q[`TCP_CC_PAIR_BIT] && run_d && !raw_d && !busy_d;
            comp_d = output_polarity ? comp_d : !comp_d;
            // interrupt scaler
            isc_d = isc_q;
            raise = 1'b0;
            tick_d = 1'b0;
            if (event_hit && ctl_q[`TCP_CC_INTERRUPT_ENABLE_BIT]) begin
                tick_d = 1'b1;
                if (isc_q >= ctl_q[20:15]) begin
                    isc_d = 6'h00;
                    raise = 1'b1;
                end else begin
                    isc_d = isc_q + 6'h01;
                end
            end
            if (!core_en) begin
                isc_d = 6'h00;
            end
        end

        always_ff @(posedge core_clk) begin
            if (reset) begin
                per_sh_q <= 16'h0000;
                cmp_sh_q <= 16'h0000;
                db_sh_q <= 8'h00;
                ctl_q <= 32'h00000000;
                per_q <= 16'h0000;
                cmp_q <= 16'h0000;
                dbc_q <= 8'h00;
                cnt_q <= 16'h0000;
                run_q <= 1'b0;
                raw_q <= 1'b0;
                busy_q <= 1'b0;
                dbn_q <= 8'h00;
                dbp_q <= 4'h0;
                isc_q <= 6'h00;
                main_q <= 1'b1;
                comp_q <= 1'b1;
                tick_q <= 1'b0;
            end else begin
                per_sh_q <= per_sh_d;
                cmp_sh_q <= cmp_sh_d;
                db_sh_q <= db_sh_d;
                ctl_q <= ctl_d;
                per_q <= per_d;
                cmp_q <= cmp_d;
                dbc_q <= dbc_d;
                cnt_q <= cnt_d;
                run_q <= run_d;
                raw_q <= raw_d;
                busy_q <= busy_d;
                dbn_q <= dbn_d;
                dbp_q <= dbp_d;
                isc_q <= isc_d;
                main_q <= main_d;
                comp_q <= comp_d;
                tick_q <= tick_d;
            end
        end

        assign irq_raise[c] = raise;
        assign rd_per[c] = per_sh_q;
        assign rd_cmp[c] = cmp_sh_q;
        assign rd_db[c] = db_sh_q;
        assign rd_ctl[c] = ctl_q;
        assign pwm_main[c] = main_q;
        assign pwm_comp[c] = comp_q;
        assign pwm_tick[c] = tick_q;
    end
endmodule // tcp_pwm

// >>> dv/tcp_load_model.sv
// load model: counts active cycles seen on the channel 0 pins
`timescale 1ns/1ps
module tcp_load_model (
    input wire logic core_clk,
    input wire logic clr,
    input wire logic [2:0] pwm_main,
    input wire logic [2:0] pwm_comp,
    input wire logic [2:0] pwm_tick,
    output logic [7:0] main_q,
    output logic [7:0] comp_q,
    output logic [7:0] both_q,
    output logic [7:0] tick_q
);
    // both high at once would short a half bridge, so it is counted apart
    always_ff @(posedge core_clk) begin
        if (clr) begin
            {main_q, comp_q, both_q, tick_q} <= 32'h0;
        end else begin
            main_q <= main_q + 8'(pwm_main[0]);
            comp_q <= comp_q + 8'(pwm_comp[0]);
            both_q <= both_q + 8'(pwm_main[0] & pwm_comp[0]);
            tick_q <= tick_q + 8'(pwm_tick[0]);
        end
    end
endmodule // tcp_load_model

// >>> dv/tcp_pwm_props.sv
// checker of bus timing, interrupt line and idle outputs of the pwm block
`timescale 1ns/1ps
module tcp_pwm_props #(
    parameter int NUM_SCALERS = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] pwm_main,
    input wire logic [2:0] pwm_comp,
    input wire logic [2:0] pwm_tick,
    input wire logic pwm_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // setup phase of a bus transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_hole: assert property (s_setup ##0 (paddr inside {[8'h14:8'h1F]}) |=> pslverr)
        else $error("reserved hole not refused");
    a_mapped_no_err: assert property (s_setup ##0 (paddr == 8'h20) |=> !pslverr)
        else $error("mapped register refused");
    a_cap_bit_read: assert property (
        s_setup ##0 (!pwrite && paddr == 8'h0C) |=> prdata == 32'h00400000)
        else $error("capability word wrong");
    // pending and irq are set on the same edge as the tick of the raising event
    a_irq_rise_tick: assert property ($rose(pwm_irq) |-> |pwm_tick)
        else $error("irq rose without tick");
    a_irq_fall_clear: assert property (
        $fell(pwm_irq) |-> $past(psel && penable && pwrite && paddr == 8'h08))
        else $error("irq fell without clear");
    a_reset_idle: assert property (
        $fell(reset) |-> pwm_main == 3'h7 && pwm_comp == 3'h7 && !pwm_irq)
        else $error("outputs not idle after reset");
endmodule // tcp_pwm_props
bind tcp_pwm tcp_pwm_props #(.NUM_SCALERS(NUM_SCALERS)) i_props(.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_main(pwm_main), .pwm_comp(pwm_comp), .pwm_tick(pwm_tick), .pwm_irq(pwm_irq));

// >>> dv/test_three_channel_pwm_with_deadband.sv
// self-checking bench of the three channel pwm block
`timescale 1ns/1ps
module test_three_channel_pwm_with_deadband;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} tcp_row_type;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, pwm_irq, clr, e;
    logic [7:0] paddr, main_q, comp_q, both_q, tick_q;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] pwm_main, pwm_comp, pwm_tick;
    int fail_count, n_tests;
    tcp_row_type rows[13] = '{'{1, 8'h00, 32'h100, 32'h100, 0}, '{1, 8'h04, 32'h12, 32'h12, 0},
        '{1, 8'h00, 32'hFFFFFFFE, 32'h7700, 0}, '{1, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 32'hFF, 0},
        '{1, 8'h2C, 32'hFFFFFFFF, 32'h03FFFC07, 0}, '{1, 8'h2C, 0, 0, 0},
        '{1, 8'h38, 32'h1FF, 32'hFF, 0}, '{1, 8'h40, 32'h1FFFF, 32'hFFFF, 0},
        '{1, 8'h0C, 0, 32'h00400000, 0}, '{0, 8'h10, 0, 0, 0}, '{1, 8'h14, 0, 0, 1},
        '{1, 8'h50, 0, 0, 1}};
    logic [31:0] irq_modes[3] = '{32'h2003, 32'h6003, 32'hA003};
    tcp_pwm i_dut(.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_main(pwm_main), .pwm_comp(pwm_comp), .pwm_tick(pwm_tick),
        .pwm_irq(pwm_irq));
    tcp_load_model i_load(.core_clk(core_clk), .clr(clr), .pwm_main(pwm_main),
        .pwm_comp(pwm_comp), .pwm_tick(pwm_tick), .main_q(main_q), .comp_q(comp_q),
        .both_q(both_q), .tick_q(tick_q));
    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            $display("unexpected %s expected %h seen %h", n, x, g);
            fail_count++;
        end
    endtask
    // one bus transfer; a missing ready ends the run
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 8);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // counts of the load over 40 clocks, ten whole periods of four
    task meas(input int wt);
        repeat (wt) @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (40) @(posedge core_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////
    // free running clock and hang guard
    initial begin
        core_clk = 0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        report_and_stop;
    end
    // main sequence
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, clr} = {1'b1, 44'h0};
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        chk("idle", 32'hE, {pwm_main, pwm_irq});
        foreach (rows[k]) begin
            if (rows[k].w) xfer(1'b1, rows[k].a, rows[k].d);
            xfer(1'b0, rows[k].a, 0);
            if (!rows[k].e) chk("rdata", rows[k].x, q);
            chk("err", 32'(rows[k].e), 32'(e));
        end
        xfer(1'b1, 8'h04, 0);
        xfer(1'b1, 8'h20, 3);
        xfer(1'b1, 8'h24, 1);
        xfer(1'b1, 8'h2C, 32'h3);
        meas(8);
        chk("main", 0, main_q);
        xfer(1'b1, 8'h00, 1);
        meas(8);
        chk("main", 20, main_q);
        chk("comp", 0, comp_q);
        xfer(1'b1, 8'h2C, 32'h7);
        meas(8);
        chk("comp", 20, comp_q);
        xfer(1'b1, 8'h2C, 32'h00200007);
        meas(8);
        chk("main", 10, main_q);
        chk("comp", 10, comp_q);
        chk("both", 0, both_q);
        foreach (irq_modes[k]) begin
            xfer(1'b1, 8'h2C, irq_modes[k]);
            meas(8);
            chk("tick", 10, tick_q);
        end
        chk("irq", 1, pwm_irq);
        // writing zeros must leave the pending bit standing
        xfer(1'b1, 8'h08, 0);
        xfer(1'b0, 8'h08, 0);
        chk("pend", 1, q);
        xfer(1'b1, 8'h2C, 32'h3);
        xfer(1'b1, 8'h08, 7);
        meas(4);
        chk("tick", 0, tick_q);
        chk("irq", 0, pwm_irq);
        xfer(1'b0, 8'h08, 0);
        chk("pend", 0, q);
        xfer(1'b1, 8'h00, 32'h1001);
        xfer(1'b1, 8'h24, 3);
        meas(8);
        chk("main", 20, main_q);
        xfer(1'b1, 8'h00, 0);
        meas(4);
        chk("main", 0, main_q);
        xfer(1'b1, 8'h00, 1);
        meas(8);
        chk("main", 0, main_q);
        report_and_stop;
    end
endmodule // test_three_channel_pwm_with_deadband
